/* File: core/cmp_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module cmp_ctrl #(
   parameter int N = 2
) (
   input wire logic clk, // 100 MHz
   input wire logic nrst, // Async reset, low
   input wire logic [3:0] addr, // Register address
   input wire logic [7:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   output logic [7:0] rdata, // Read data, cycle after rd
   input wire logic [N-1:0] cmp_raw, // Raw analog results
   input wire logic tmr_clk, // Prescaled timer clock
   input wire logic tmr_on_sys, // Timer fed by system clock
   input wire logic sleep, // Device asleep
   output logic [N-1:0] core_on, // Analog core power
   output logic [N-1:0] core_sep, // Hysteresis enable
   output logic [N-1:0][2:0] minus_sel, // Minus mux code
   output logic [N-1:0] minus_conn, // Minus mux connected
   output logic [N-1:0][2:0] plus_sel, // Plus mux code
   output logic [N-1:0] plus_conn, // Plus mux connected
   output logic [N-1:0] tmr_gate, // Result to timer gate
   output logic [N-1:0] pin_out, // Result to pin
   output logic [N-1:0] shutdown_src, // Result to wave unit
   output logic [N-1:0] irq_flag, // Sticky flags
   output logic wake_req // Wake from sleep
);
   //--------------------------------------------------
   // Reset release and input synchronisers
   //--------------------------------------------------
   logic [1:0] rst_sh_r;
   logic rst_n;
   logic [N-1:0] raw_s1_r;
   logic [N-1:0] raw_s2_r;
   logic [2:0] tck_r;
   logic [1:0] tsys_r;
   logic tfall;
   logic hold;

   // Two-stage reset release
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rst_sh_r <= 2'h0;
      else
         rst_sh_r <= {rst_sh_r[0], 1'b1};
   end
   assign rst_n = rst_sh_r[1];

   // Raw results through two flops
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         raw_s1_r <= '0;
         raw_s2_r <= '0;
      end
      else
      begin
         raw_s1_r <= cmp_raw;
         raw_s2_r <= raw_s1_r;
      end
   end

   // Timer clock through three flops, source level through two
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tck_r <= 3'h0;
         tsys_r <= 2'h0;
      end
      else
      begin
         tck_r <= {tck_r[1:0], tmr_clk};
         tsys_r <= {tsys_r[0], tmr_on_sys};
      end
   end
   assign tfall = tck_r[2] & ~tck_r[1]; // RULE20
   assign hold = sleep & tsys_r[1]; // RULE15

   //--------------------------------------------------
   // Register file
   //--------------------------------------------------
   cmp_pkg::ctl_t ctl_r [N];
   cmp_pkg::edge_en_t een_r [N];
   logic [2:0] nsel_r [N];
   logic [2:0] psel_r [N];
   logic [N-1:0] ien_r;
   logic [N-1:0] result_r;
   logic [N-1:0] prev_r;
   logic [N-1:0] sync_q_r;
   logic [N-1:0] flag_r;
   logic [N-1:0] set_ev;
   logic [N-1:0] clr_ev;
   logic [N-1:0] rise_ev;
   logic [N-1:0] fall_ev;

   // Register hit for comparator i, register k
   function automatic logic hit(input logic [3:0] a, input int i,
                                input logic [1:0] k);
      hit = (a[3:2] == i[1:0]) && (a[1:0] == k);
   endfunction

   // Control writes; only implemented bits stored
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < N; i++)
         begin
            ctl_r[i] <= '0; // RULE13
            een_r[i] <= '0;
            nsel_r[i] <= cmp_pkg::SEL_RST;
            psel_r[i] <= cmp_pkg::SEL_RST;
         end
      end
      else if (wr)
      begin
         for (int i = 0; i < N; i++)
         begin
            if (hit(addr, i, cmp_pkg::R_CON0))
            begin
               ctl_r[i].on <= wdata[cmp_pkg::B_ON]; // RULE3
               ctl_r[i].inv <= wdata[cmp_pkg::B_INV]; // RULE5
               ctl_r[i].sep <= wdata[cmp_pkg::B_SEP]; // RULE6
               ctl_r[i].sync_mode <= wdata[cmp_pkg::B_SYNC]; // RULE7
            end
            if (hit(addr, i, cmp_pkg::R_CON1))
            begin
               een_r[i].rise <= wdata[cmp_pkg::B_RISE]; // RULE9
               een_r[i].fall <= wdata[cmp_pkg::B_FALL]; // RULE10
            end
            if (hit(addr, i, cmp_pkg::R_NSEL))
               nsel_r[i] <= wdata[2:0]; // RULE12
            if (hit(addr, i, cmp_pkg::R_PSEL))
               psel_r[i] <= wdata[2:0]; // RULE21
         end
      end
   end

   // Flag enables
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ien_r <= '0;
      else if (wr && addr == cmp_pkg::A_IEN)
         ien_r <= wdata[N-1:0];
   end

   //--------------------------------------------------
   // Result sampling, edges and flags
   //--------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_cmp
         // Disabled core reads low before inversion
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               result_r[g] <= 1'b0;
               prev_r[g] <= 1'b0;
            end
            else
            begin
               result_r[g] <= (ctl_r[g].on & raw_s2_r[g]) ^ ctl_r[g].inv; // RULE4 RULE18 RULE19
               prev_r[g] <= result_r[g]; // RULE22
            end
         end
         assign rise_ev[g] = result_r[g] & ~prev_r[g]; // RULE22
         assign fall_ev[g] = ~result_r[g] & prev_r[g];
         assign set_ev[g] = (een_r[g].rise & rise_ev[g]) // RULE9
                          | (een_r[g].fall & fall_ev[g]); // RULE10

         // Timer-retimed copy, frozen while the timer halts
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               sync_q_r[g] <= 1'b0;
            else if (tfall && !hold)
               sync_q_r[g] <= result_r[g]; // RULE7 RULE15 RULE20
         end

         // Outputs to gate, pin and wave unit
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               tmr_gate[g] <= 1'b0;
               pin_out[g] <= 1'b0;
               shutdown_src[g] <= 1'b0;
            end
            else
            begin
               tmr_gate[g] <= ctl_r[g].sync_mode ? sync_q_r[g] : result_r[g]; // RULE7 RULE8
               pin_out[g] <= ctl_r[g].sync_mode ? sync_q_r[g] : result_r[g]; // RULE8
               shutdown_src[g] <= result_r[g]; // RULE14
            end
         end

         // Analog mux connection decode; all inputs off when disabled
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               minus_conn[g] <= 1'b0;
               plus_conn[g] <= 1'b0;
            end
            else
            begin
               minus_conn[g] <= ctl_r[g].on && (nsel_r[g] <= cmp_pkg::N_LAST_PIN
                               || nsel_r[g] >= cmp_pkg::SEL_FIXREF); // RULE1
               plus_conn[g] <= ctl_r[g].on && (psel_r[g] <= cmp_pkg::P_LAST_PIN
                               || psel_r[g] >= cmp_pkg::P_DAC); // RULE2
            end
         end

         assign core_on[g] = ctl_r[g].on; // RULE3
         assign core_sep[g] = ctl_r[g].sep; // RULE6
         assign minus_sel[g] = nsel_r[g]; // RULE1
         assign plus_sel[g] = psel_r[g]; // RULE2
      end
   endgenerate

   // Software writes zero to clear; set wins
   assign clr_ev = (wr && addr == cmp_pkg::A_FLAGS) ? ~wdata[N-1:0] : '0;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         flag_r <= '0;
      else
         flag_r <= set_ev | (flag_r & ~clr_ev); // RULE17
   end
   assign irq_flag = flag_r;

   // Wake request
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         wake_req <= 1'b0;
      else
         wake_req <= |(flag_r & ien_r); // RULE16
   end

   //--------------------------------------------------
   // Read path
   //--------------------------------------------------
   function automatic logic [7:0] rd_mux(input logic [3:0] a);
      logic [7:0] v;
      v = cmp_pkg::ZERO_BYTE; // RULE12
      for (int i = 0; i < N; i++)
      begin
         if (hit(a, i, cmp_pkg::R_CON0))
         begin
            v[cmp_pkg::B_ON] = ctl_r[i].on;
            v[cmp_pkg::B_OUT] = result_r[i]; // RULE4
            v[cmp_pkg::B_INV] = ctl_r[i].inv;
            v[cmp_pkg::B_SEP] = ctl_r[i].sep;
            v[cmp_pkg::B_SYNC] = ctl_r[i].sync_mode;
         end
         if (hit(a, i, cmp_pkg::R_CON1))
         begin
            v[cmp_pkg::B_RISE] = een_r[i].rise;
            v[cmp_pkg::B_FALL] = een_r[i].fall;
         end
         if (hit(a, i, cmp_pkg::R_NSEL))
            v[2:0] = nsel_r[i];
         if (hit(a, i, cmp_pkg::R_PSEL))
            v[2:0] = psel_r[i];
      end
      if (a == cmp_pkg::A_MIRROR)
         v[N-1:0] = result_r; // RULE11
      if (a == cmp_pkg::A_FLAGS)
         v[N-1:0] = flag_r;
      if (a == cmp_pkg::A_IEN)
         v[N-1:0] = ien_r;
      rd_mux = v;
   endfunction

   // Read data stands one cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= cmp_pkg::ZERO_BYTE;
      else if (rd)
         rdata <= rd_mux(addr);
      else
         rdata <= cmp_pkg::ZERO_BYTE;
   end

   //--------------------------------------------------
   // Assertions
   //--------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   property p_rise_flag;
      een_r[0].rise && rise_ev[0] |=> flag_r[0];
   endproperty
   a_rise_flag: assert property (p_rise_flag) else $error("rise lost"); // RULE9

   property p_fall_flag;
      een_r[0].fall && fall_ev[0] |=> flag_r[0];
   endproperty
   a_fall_flag: assert property (p_fall_flag) else $error("fall lost"); // RULE10

   property p_flag_cause;
      $rose(flag_r[1]) |-> $past(set_ev[1]);
   endproperty
   a_flag_cause: assert property (p_flag_cause) else $error("flag no cause"); // RULE22

   property p_set_wins;
      set_ev[0] && clr_ev[0] |=> flag_r[0];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat set"); // RULE17

   property p_mirror;
      rd && addr == cmp_pkg::A_MIRROR |=> rdata == {6'h00, $past(result_r)};
   endproperty
   a_mirror: assert property (p_mirror) else $error("mirror wrong"); // RULE11

   property p_unmapped;
      rd && addr == 4'hF |=> rdata == cmp_pkg::ZERO_BYTE;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped nonzero"); // RULE12

   property p_async_out;
      !ctl_r[0].sync_mode |=>
         tmr_gate[0] == $past(result_r[0]) && pin_out[0] == tmr_gate[0];
   endproperty
   a_async_out: assert property (p_async_out) else $error("async out wrong"); // RULE8

   property p_sync_hold;
      !tfall || hold |=> $stable(sync_q_r[0]);
   endproperty
   a_sync_hold: assert property (p_sync_hold) else $error("sync moved"); // RULE7

   property p_wake;
      flag_r[0] && ien_r[0] |=> wake_req;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake"); // RULE16

   property p_off_shut;
      !ctl_r[0].on && !ctl_r[0].inv ##1 !ctl_r[0].on |=> !shutdown_src[0];
   endproperty
   a_off_shut: assert property (p_off_shut) else $error("shutdown while off"); // RULE14

   property p_open_minus;
      nsel_r[0] == 3'h4 |=> !minus_conn[0];
   endproperty
   a_open_minus: assert property (p_open_minus) else $error("open minus conn"); // RULE1

   c_rise: cover property (een_r[0].rise && rise_ev[0] ##1 flag_r[0]);
   c_set_clr: cover property (set_ev[0] && clr_ev[0]);
   c_sync: cover property (ctl_r[0].sync_mode && tfall && !hold);
   c_wake: cover property ($rose(wake_req));
endmodule // cmp_ctrl
`default_nettype wire

/* File: core/cmp_pkg.sv */
// Operation
// RULE1 - Minus select: 0-3 pins, 4-5 open, 6 fixed reference, 7 ground
// RULE2 - Plus select: 0-1 pins, 2-4 open, 5 DAC, 6 reference, 7 ground
// RULE3 - Control bit 7 enables; clear powers the analog core down
// RULE4 - Result bit 6 is one when plus exceeds minus, reversed if inverted
// RULE5 - Invert bit 4 flips result for status, edges, gate, pin, shutdown
// RULE6 - Control bit 1 drives the core separation (hysteresis) enable
// RULE7 - Sync bit 0 updates gate and pin on timer clock falling edge
// RULE8 - Sync bit clear: gate and pin follow the result without retiming
// RULE9 - Edge enable bit 1 lets a rising result set the flag
// RULE10 - Edge enable bit 0 lets a falling result set the flag
// RULE11 - Mirror register: comparator two at bit 1, one at bit 0
// RULE12 - Unimplemented bits ignore writes and read zero
// RULE13 - All implemented bits reset to zero on every reset
// RULE14 - Result feeds the wave unit as a shutdown source
// RULE15 - Sync path stops in sleep when timer runs from system clock
// RULE16 - Set flag with its enable raises a wake request
// RULE17 - Flag cleared only by software; a same-cycle edge keeps it set
// RULE18 - Raw result is sampled into a register each cycle
// RULE19 - Invert or enable changes while disabled can still raise a flag
// RULE20 - Sync latching uses the prescaled timer clock
// RULE21 - Two instances with own registers and flags share one mirror
// RULE22 - Edges compare current and previous samples, one-cycle pulse
package cmp_pkg;
   // Register map: addr[3:2] picks the comparator, addr[1:0] the register
   localparam logic [1:0] R_CON0 = 2'h0;
   localparam logic [1:0] R_CON1 = 2'h1;
   localparam logic [1:0] R_NSEL = 2'h2;
   localparam logic [1:0] R_PSEL = 2'h3;
   localparam logic [3:0] A_MIRROR = 4'h8;
   localparam logic [3:0] A_FLAGS = 4'h9;
   localparam logic [3:0] A_IEN = 4'hA;
   // Bit positions
   localparam int B_ON = 7;
   localparam int B_OUT = 6;
   localparam int B_INV = 4;
   localparam int B_SEP = 1;
   localparam int B_SYNC = 0;
   localparam int B_RISE = 1;
   localparam int B_FALL = 0;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // Mux codes
   localparam logic [2:0] N_LAST_PIN = 3'h3;
   localparam logic [2:0] P_LAST_PIN = 3'h1;
   localparam logic [2:0] P_DAC = 3'h5;
   localparam logic [2:0] SEL_FIXREF = 3'h6;
   localparam logic [2:0] SEL_GND = 3'h7;
   localparam logic [2:0] SEL_RST = 3'h0;

   typedef struct packed {
      logic on;
      logic inv;
      logic sep;
      logic sync_mode;
   } ctl_t;

   typedef struct packed {
      logic rise;
      logic fall;
   } edge_en_t;
endpackage

/* File: tb/cmp_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Analog core and timer clock stand-in
// ----------------------------------------
module cmp_core_model #(
   parameter int N = 2
) (
   input wire logic clk, // Paces the floating output
   input wire logic [N-1:0] core_on, // Core power
   input wire logic [N-1:0][2:0] minus_sel, // Minus mux code
   input wire logic [N-1:0][2:0] plus_sel, // Plus mux code
   input wire logic [N-1:0][7:0] ext_lvl, // Level on the plus pins
   input wire logic tmr_en, // Timer clock runs
   output logic [N-1:0] cmp_raw, // Raw results
   output logic tmr_clk // Prescaled timer clock
);
   logic [7:0] vp [N];
   logic [7:0] vm [N];
   logic [N-1:0] float_r;
   logic [N-1:0] open_in;
   // Mux decode, open inputs and unpowered core flicker
   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         vm[i] = minus_sel[i][2] ? {minus_sel[i][0] ? 8'h00 : 8'h80} : {minus_sel[i][1:0], 6'h00};
         vp[i] = plus_sel[i] == 3'h5 ? 8'hC0 : plus_sel[i] == 3'h6 ? 8'h80 : ext_lvl[i];
         if (plus_sel[i] == 3'h7)
            vp[i] = 8'h00;
         open_in[i] = (minus_sel[i] inside {3'h4, 3'h5}) || (plus_sel[i] inside {3'h2, 3'h3, 3'h4});
         cmp_raw[i] = (!core_on[i] || open_in[i]) ? float_r[i] : (vp[i] > vm[i]);
      end
   end
   // Floating level changes every cycle
   initial float_r = '0;
   always @(posedge clk) float_r <= ~float_r;
   // Timer clock, held high while stopped
   initial tmr_clk = 1'b1;
   always
   begin
      #23;
      tmr_clk = tmr_en ? ~tmr_clk : 1'b1;
   end
endmodule // cmp_core_model
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bench top
// ----------------------------------------
module tb;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic [1:0] cmp_raw, core_on, core_sep, minus_conn, plus_conn;
   logic [1:0] tmr_gate, pin_out, shutdown_src, irq_flag;
   logic [1:0][2:0] minus_sel, plus_sel;
   logic [1:0][7:0] ext_lvl = {8'h10, 8'h10};
   logic tmr_clk, wake_req;
   logic tmr_en = 1'b0;
   logic tmr_on_sys = 1'b0;
   logic sleep = 1'b0;
   int failures = 0;
   int samples_checked = 0;
   cmp_ctrl #(.N(2)) uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .cmp_raw(cmp_raw), .tmr_clk(tmr_clk), .tmr_on_sys(tmr_on_sys),
      .sleep(sleep), .core_on(core_on), .core_sep(core_sep), .minus_sel(minus_sel),
      .minus_conn(minus_conn), .plus_sel(plus_sel), .plus_conn(plus_conn),
      .tmr_gate(tmr_gate), .pin_out(pin_out), .shutdown_src(shutdown_src),
      .irq_flag(irq_flag), .wake_req(wake_req));
   cmp_core_model #(.N(2)) core (.clk(clk), .core_on(core_on), .minus_sel(minus_sel),
      .plus_sel(plus_sel), .ext_lvl(ext_lvl), .tmr_en(tmr_en), .cmp_raw(cmp_raw),
      .tmr_clk(tmr_clk));
   // Clock
   initial
   begin
      forever #5 clk = ~clk;
   end
   // ----------------------------------------
   // Bus and compare helpers
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata & mask, exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic stop_test;
      $display("failures=%0d samples_checked=%0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset_vals;
      for (int a = 0; a < 16; a++)
         rd_chk(a[3:0], 8'hFF, 8'h00);
      chk({core_on, core_sep, irq_flag, 1'b0, wake_req}, 8'h00);
   endtask
   task automatic t_rw_masks;
      wr_reg(4'h0, 8'hFF);
      rd_chk(4'h0, 8'hBF, 8'h93);
      chk({6'h0, core_on[0], core_sep[0]}, 8'h03);
      for (int k = 1; k < 4; k++)
      begin
         wr_reg(k[3:0], 8'hFF);
         rd_chk(k[3:0], 8'hFF, k == 1 ? 8'h03 : 8'h07);
      end
      wr_reg(4'hB, 8'hFF);
      rd_chk(4'hB, 8'hFF, 8'h00);
      for (int k = 0; k < 4; k++)
         wr_reg(k[3:0], 8'h00);
      settle(1);
      chk({6'h0, core_on[0], core_sep[0]}, 8'h00);
   endtask
   task automatic t_mux;
      wr_reg(4'h0, 8'h80);
      for (int c = 0; c < 8; c++)
      begin
         wr_reg({2'h0, cmp_pkg::R_NSEL}, c[7:0]);
         wr_reg({2'h0, cmp_pkg::R_PSEL}, c[7:0]);
         settle(2);
         chk({4'h0, minus_sel[0], minus_conn[0]}, {4'h0, c[2:0], !(c inside {4, 5})});
         chk({4'h0, plus_sel[0], plus_conn[0]}, {4'h0, c[2:0], !(c inside {2, 3, 4})});
      end
      wr_reg(4'h0, 8'h00);
      settle(2);
      chk({6'h0, minus_conn[0], plus_conn[0]}, 8'h00);
   endtask
   task automatic t_result;
      wr_reg({2'h0, cmp_pkg::R_NSEL}, 8'h01);
      wr_reg({2'h0, cmp_pkg::R_PSEL}, 8'h00);
      wr_reg(4'h0, 8'h80);
      ext_lvl[0] <= 8'h80;
      settle(6);
      rd_chk(4'h0, 8'hFF, 8'hC0);
      rd_chk(cmp_pkg::A_MIRROR, 8'hFF, 8'h01);
      chk({5'h0, shutdown_src[0], tmr_gate[0], pin_out[0]}, 8'h07);
      wr_reg(4'h0, 8'h90);
      settle(6);
      rd_chk(4'h0, 8'hFF, 8'h90);
      chk({5'h0, shutdown_src[0], tmr_gate[0], pin_out[0]}, 8'h00);
      ext_lvl[0] <= 8'h10;
      settle(6);
      rd_chk(4'h0, 8'hFF, 8'hD0);
   endtask
   task automatic t_edges;
      wr_reg(4'h0, 8'h80);
      wr_reg(cmp_pkg::A_IEN, 8'h01);
      wr_reg({2'h0, cmp_pkg::R_CON1}, 8'h02);
      settle(6);
      wr_reg(cmp_pkg::A_FLAGS, 8'h00);
      ext_lvl[0] <= 8'h80;
      settle(2);
      // Clear lands in the cycle of the rising pulse
      wr_reg(cmp_pkg::A_FLAGS, 8'h00);
      settle(4);
      chk({6'h0, irq_flag[0], wake_req}, 8'h03);
      rd_chk(cmp_pkg::A_FLAGS, 8'hFF, 8'h01);
      wr_reg(cmp_pkg::A_FLAGS, 8'h00);
      ext_lvl[0] <= 8'h10;
      settle(6);
      chk({7'h0, irq_flag[0]}, 8'h00);
      wr_reg({2'h0, cmp_pkg::R_CON1}, 8'h01);
      ext_lvl[0] <= 8'h80;
      settle(6);
      chk({7'h0, irq_flag[0]}, 8'h00);
      ext_lvl[0] <= 8'h10;
      settle(6);
      chk({7'h0, irq_flag[0]}, 8'h01);
      wr_reg(cmp_pkg::A_IEN, 8'h00);
      settle(2);
      chk({7'h0, wake_req}, 8'h00);
      wr_reg({2'h0, cmp_pkg::R_CON1}, 8'h00);
      wr_reg(4'h0, 8'h00);
      settle(6);
      wr_reg(cmp_pkg::A_FLAGS, 8'h00);
      wr_reg({2'h0, cmp_pkg::R_CON1}, 8'h03);
      wr_reg(4'h0, 8'h10);
      settle(6);
      chk({7'h0, irq_flag[0]}, 8'h01);
      wr_reg({2'h0, cmp_pkg::R_CON1}, 8'h00);
   endtask
   task automatic t_sync;
      wr_reg(4'h0, 8'h81);
      ext_lvl[0] <= 8'h80;
      tmr_en <= 1'b1;
      settle(20);
      chk({6'h0, tmr_gate[0], pin_out[0]}, 8'h03);
      tmr_en <= 1'b0;
      settle(10);
      ext_lvl[0] <= 8'h10;
      settle(20);
      rd_chk(4'h0, 8'hFF, 8'h81);
      chk({6'h0, tmr_gate[0], shutdown_src[0]}, 8'h02);
      tmr_en <= 1'b1;
      settle(20);
      chk({6'h0, tmr_gate[0], pin_out[0]}, 8'h00);
      sleep <= 1'b1;
      tmr_on_sys <= 1'b1;
      ext_lvl[0] <= 8'h80;
      settle(20);
      chk({7'h0, tmr_gate[0]}, 8'h00);
      sleep <= 1'b0;
      settle(20);
      chk({7'h0, tmr_gate[0]}, 8'h01);
      tmr_en <= 1'b0;
   endtask
   task automatic t_second;
      wr_reg(4'h0, 8'h00);
      wr_reg(4'h6, 8'h01);
      wr_reg(4'h7, 8'h01);
      wr_reg(4'h4, 8'h80);
      ext_lvl[1] <= 8'h80;
      settle(6);
      rd_chk(cmp_pkg::A_MIRROR, 8'hFF, 8'h02);
      rd_chk(4'h4, 8'hFF, 8'hC0);
      chk({6'h0, core_on}, 8'h02);
   endtask
   // Reset again mid-run; everything back to zero
   task automatic t_reset_again;
      @(posedge clk);
      nrst <= 1'b0;
      settle(2);
      nrst <= 1'b1;
      settle(3);
      rd_chk(4'h4, 8'hFF, 8'h00);
      rd_chk(cmp_pkg::A_FLAGS, 8'hFF, 8'h00);
      chk({core_on, irq_flag, tmr_gate, shutdown_src}, 8'h00);
   endtask
   // Main sequence
   initial
   begin
      settle(2);
      nrst <= 1'b1;
      settle(3);
      t_reset_vals();
      t_rw_masks();
      t_mux();
      t_result();
      t_edges();
      t_sync();
      t_second();
      t_reset_again();
      stop_test();
   end
   // Watchdog
   initial
   begin
      #100000;
      failures++;
      stop_test();
   end
endmodule // tb
`default_nettype wire
